// *** common/dbg_link_pkg.sv ***
package dbg_link_pkg;
   // Register indices within the interface register space
   localparam logic [3:0] OFS_REV_STATUS    = 4'h0;
   localparam logic [3:0] OFS_ERR_STATUS    = 4'h1;
   localparam logic [3:0] OFS_PHY_CTRL      = 4'h2;
   localparam logic [3:0] OFS_PHY_DIS_CTRL  = 4'h3;
   localparam logic [3:0] OFS_KEY_STATUS    = 4'h7;
   localparam logic [3:0] OFS_RESET_REQ     = 4'h8;
   localparam logic [3:0] OFS_CLK_SELECT    = 4'h9;
   localparam logic [3:0] OFS_SYS_CTRL      = 4'hA;
   localparam logic [3:0] OFS_SYS_STATUS    = 4'hB;
   localparam logic [3:0] OFS_MEM_CHECK     = 4'hC;
   localparam logic [3:0] OFS_PHY_LAST      = 4'h3;

   // Revision value is arbitrary
   localparam logic [3:0] INTERFACE_REVISION = 4'h3;
   localparam int         REV_LSB            = 4;

   // Control field positions
   localparam int IBG_BIT   = 7;
   localparam int PAR_BIT   = 5;
   localparam int TMO_BIT   = 4;
   localparam int RSIG_BIT  = 3;
   localparam int HOLD_BIT  = 0;
   localparam int ASLEEP_BIT = 4;
   localparam logic [7:0] PHY_CTRL_MASK  = 8'hBF;
   localparam logic [7:0] PHY_DIS_MASK   = 8'h1C;
   localparam logic [7:0] PHY_CTRL_RESET = 8'h00;
   localparam logic [7:0] PHY_DIS_RESET  = 8'h00;
   localparam logic [7:0] CLK_SEL_RESET  = 8'h03;
   localparam logic       HOLD_RESET     = 1'b1;

   // Error signatures
   localparam logic [2:0] ERR_NONE     = 3'h0;
   localparam logic [2:0] ERR_PARITY   = 3'h1;
   localparam logic [2:0] ERR_FRAME    = 3'h2;
   localparam logic [2:0] ERR_TIMEOUT  = 3'h3;
   localparam logic [2:0] ERR_START    = 3'h4;
   localparam logic [2:0] ERR_CONTEND  = 3'h7;

   // Timing in interface clock cycles
   localparam int TIMEOUT_CYCLES = 65536;
   localparam int GUARD_MAX_CYCLES = 128;
   localparam int IDLE_CHAR_BITS = 12;
   localparam int INTERBYTE_CYCLES = 2 * IDLE_CHAR_BITS;
   localparam logic [2:0] GUARD_OFF = 3'h7;
endpackage

// *** common/gap_if.sv ***
`timescale 1ns/10ps
interface gap_if;
   logic       start;
   logic [7:0] cycles;
   logic       busy;
   modport ctrl (output start, output cycles, input busy);
   modport timer (input start, input cycles, output busy);
endinterface

// *** hw/gap_timer.sv ***
`timescale 1ns/10ps
module gap_timer (
   input  wire logic clk,
   input  wire logic rst_n,
   gap_if.timer      gap
);
   logic [7:0] count_r;
   logic [7:0] count_nxt;

   // A zero load means no wait at all
   assign count_nxt = gap.start ? gap.cycles :
                      (count_r != 8'h00) ? count_r - 8'h01 : 8'h00;
   assign gap.busy  = (count_r != 8'h00);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= 8'h00;
      end else begin
         count_r <= count_nxt;
      end
   end
endmodule

// *** hw/access_watchdog.sv ***
`timescale 1ns/10ps
module access_watchdog (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic armed,
   input  wire logic checkOff,
   output logic      expired
);
   logic [16:0] wait_r;

   // Counter stops at 65536, one count past expiry, so one pending access yields one event
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_r <= 17'h00000;
      end else if (!armed || checkOff) begin
         wait_r <= 17'h00000;
      end else if (!wait_r[16]) begin
         wait_r <= wait_r + 17'h00001;
      end
   end

   assign expired = armed && !checkOff &&
                    (wait_r == 17'(dbg_link_pkg::TIMEOUT_CYCLES - 1));
endmodule

// *** hw/debug_link_phy_config_status.sv ***
// Overview of operation
// - Interface logic keeps running in every system sleep mode.
// - Bus access blocked when processor clock is stopped by sleep and clock hold is off.
// - Interface clock runs whenever interface enabled, ignoring sleep settings.
// - Asleep flag reads one in idle sleep or deeper, else zero.
// - Clock hold keeps system clock running; sleep only emulated.
// - Clock hold bit resets to one.
// - Registers reachable only over the debug link, not the processor.
// - Phy registers at 0x0-0x3, access layer at 0x4-0xC.
// - Revision is read-only in bits 7:4 of status register zero.
// - Error signature bits 2:0 load on error, clear on debugger read.
// - Codes: parity 0x1, stop bits 0x2, start bit 0x4.
// - Code 0x3 when access layer gives no response.
// - Code 0x7 on line contention; 0x5 and 0x6 never reported.
// - Gap enable inserts two idle characters between burst load bytes.
// - First burst byte waits only the turnaround guard time.
// - Parity check off ignores parity and never flags parity errors.
// - Time-out after 65536 cycles without response unless check off.
// - Response signature off suppresses every response signature.
// - Guard select: 0 gives 128 cycles, halving to 2; 7 none.
`timescale 1ns/10ps
module debug_link_phy_config_status (
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Register port driven by the link's instruction decoder only
   input  wire logic       regWrite,
   input  wire logic       regRead,
   input  wire logic [3:0] regAddr,
   input  wire logic [7:0] regWdata,
   output logic [7:0]      regRdata,
   // Error events from the character receiver and line monitor
   input  wire logic       parityBad,
   input  wire logic       stopBad,
   input  wire logic       startBad,
   input  wire logic       contention,
   // Access layer handshake
   input  wire logic       accessReq,
   input  wire logic       accessAck,
   // System sleep state, from another domain
   input  wire logic       sysSleepIdle,
   input  wire logic       cpuClockOff,
   // Transmit sequencing
   input  wire logic       txByteReq,
   input  wire logic       txFirstByte,
   input  wire logic       txIsSignature,
   output logic            txGo,
   output logic            txSuppress,
   output logic            sysClockHold,
   output logic            busReachable
);
   logic [7:0] phyCtrl_r;
   logic [7:0] phyDis_r;
   logic [7:0] clkSel_r;
   logic       hold_r;
   logic [2:0] errSig_r;
   logic [2:0] errSig_nxt;
   logic [7:0] regRdata_r;
   logic [7:0] rdMux;
   logic       txGo_r;
   logic       txSuppress_r;
   logic       busReach_r;
   logic       sleepMeta_r;
   logic       sleepSync_r;
   logic       offMeta_r;
   logic       offSync_r;
   logic       timeoutEvt;
   logic       pending_r;

   gap_if gap ();

   gap_timer u_gap (
      .clk   (clk),
      .rst_n (rst_n),
      .gap   (gap)
   );

   access_watchdog u_wd (
      .clk      (clk),
      .rst_n    (rst_n),
      .armed    (pending_r),
      .checkOff (phyCtrl_r[dbg_link_pkg::TMO_BIT]),
      .expired  (timeoutEvt)
   );

   typedef enum logic [2:0] {
      TX_IDLE = 3'b001,
      TX_WAIT = 3'b010,
      TX_SEND = 3'b100
   } tx_state_e;

   tx_state_e txState_r;
   tx_state_e txState_nxt;

   // Sleep state crosses from the system domain
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sleepMeta_r <= 1'b0;
         sleepSync_r <= 1'b0;
         offMeta_r   <= 1'b0;
         offSync_r   <= 1'b0;
      end else begin
         sleepMeta_r <= sysSleepIdle;
         sleepSync_r <= sleepMeta_r;
         offMeta_r   <= cpuClockOff;
         offSync_r   <= offMeta_r;
      end
   end

   // Register writes; this port is the only path
   wire wrCtrl = regWrite && (regAddr == dbg_link_pkg::OFS_PHY_CTRL);
   wire wrDis  = regWrite && (regAddr == dbg_link_pkg::OFS_PHY_DIS_CTRL);
   wire wrSel  = regWrite && (regAddr == dbg_link_pkg::OFS_CLK_SELECT);
   wire wrSys  = regWrite && (regAddr == dbg_link_pkg::OFS_SYS_CTRL);
   wire rdErr  = regRead && (regAddr == dbg_link_pkg::OFS_ERR_STATUS);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phyCtrl_r <= dbg_link_pkg::PHY_CTRL_RESET;
         phyDis_r  <= dbg_link_pkg::PHY_DIS_RESET;
         clkSel_r  <= dbg_link_pkg::CLK_SEL_RESET;
         hold_r    <= dbg_link_pkg::HOLD_RESET;
      end else begin
         if (wrCtrl) begin
            phyCtrl_r <= regWdata & dbg_link_pkg::PHY_CTRL_MASK;
         end
         if (wrDis) begin
            phyDis_r <= regWdata & dbg_link_pkg::PHY_DIS_MASK;
         end
         if (wrSel) begin
            clkSel_r <= {6'h00, regWdata[1:0]};
         end
         if (wrSys) begin
            hold_r <= regWdata[dbg_link_pkg::HOLD_BIT];
         end
      end
   end

   // Error events, highest code first; parity masked when checks are off
   wire parityEvt = parityBad && !phyCtrl_r[dbg_link_pkg::PAR_BIT];
   wire anyErr    = contention || startBad || timeoutEvt || stopBad || parityEvt;
   assign errSig_nxt = contention ? dbg_link_pkg::ERR_CONTEND :
                       startBad   ? dbg_link_pkg::ERR_START :
                       timeoutEvt ? dbg_link_pkg::ERR_TIMEOUT :
                       stopBad    ? dbg_link_pkg::ERR_FRAME :
                       parityEvt  ? dbg_link_pkg::ERR_PARITY :
                       dbg_link_pkg::ERR_NONE;

   // A new error in the read cycle wins over the clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         errSig_r <= dbg_link_pkg::ERR_NONE;
      end else if (anyErr) begin
         errSig_r <= errSig_nxt;
      end else if (rdErr) begin
         errSig_r <= dbg_link_pkg::ERR_NONE;
      end
   end

   // Outstanding access; ended by acknowledge or time-out
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pending_r <= 1'b0;
      end else if (accessAck || timeoutEvt) begin
         pending_r <= 1'b0;
      end else if (accessReq) begin
         pending_r <= 1'b1;
      end
   end

   // Read mux; offsets 0x0-0x3 phy, 0x4-0xC access layer
   wire [7:0] sysStatus = 8'(sleepSync_r) << dbg_link_pkg::ASLEEP_BIT;
   always_comb begin
      case (regAddr)
         dbg_link_pkg::OFS_REV_STATUS:
            rdMux = {dbg_link_pkg::INTERFACE_REVISION, 4'h0};
         dbg_link_pkg::OFS_ERR_STATUS:   rdMux = {5'h00, errSig_r};
         dbg_link_pkg::OFS_PHY_CTRL:     rdMux = phyCtrl_r;
         dbg_link_pkg::OFS_PHY_DIS_CTRL: rdMux = phyDis_r;
         dbg_link_pkg::OFS_CLK_SELECT:   rdMux = clkSel_r;
         dbg_link_pkg::OFS_SYS_CTRL:     rdMux = {7'h00, hold_r};
         dbg_link_pkg::OFS_SYS_STATUS:   rdMux = sysStatus;
         default:                        rdMux = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         regRdata_r <= 8'h00;
      end else if (regRead) begin
         regRdata_r <= rdMux;
      end
   end
   assign regRdata = regRdata_r;

   // Turnaround guard: 128 >> select, select 7 gives no wait
   wire [2:0] guardSel = phyCtrl_r[2:0];
   wire [7:0] guardCycles = (guardSel == dbg_link_pkg::GUARD_OFF) ? 8'h00 :
                            8'(dbg_link_pkg::GUARD_MAX_CYCLES >> guardSel);
   wire gapOn = phyCtrl_r[dbg_link_pkg::IBG_BIT];
   wire [7:0] waitCycles = txFirstByte ? guardCycles :
                           gapOn ? 8'(dbg_link_pkg::INTERBYTE_CYCLES) :
                           8'h00;

   assign gap.start  = (txState_r == TX_IDLE) && txByteReq;
   assign gap.cycles = waitCycles;

   always_comb begin
      case (txState_r)
         TX_IDLE: txState_nxt = txByteReq ? TX_WAIT : TX_IDLE;
         TX_WAIT: txState_nxt = gap.busy ? TX_WAIT : TX_SEND;
         TX_SEND: txState_nxt = TX_IDLE;
         default: txState_nxt = TX_IDLE;
      endcase
   end

   wire suppressNow = txIsSignature && phyCtrl_r[dbg_link_pkg::RSIG_BIT];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         txState_r    <= TX_IDLE;
         txGo_r       <= 1'b0;
         txSuppress_r <= 1'b0;
         busReach_r   <= 1'b0;
      end else begin
         txState_r    <= txState_nxt;
         txGo_r       <= (txState_r == TX_WAIT) && !gap.busy;
         txSuppress_r <= suppressNow;
         // Held clock emulates sleep, so bus stays reachable
         busReach_r   <= hold_r || !offSync_r;
      end
   end

   // Interface clock and this logic never gate on sleep
   assign txGo         = txGo_r;
   assign txSuppress   = txSuppress_r;
   assign sysClockHold = hold_r;
   assign busReachable = busReach_r;

   a_hold_reset: assert property (@(posedge clk) $rose(rst_n) |-> hold_r)
      else $error("clock hold not one after reset");
   a_err_clear: assert property (@(posedge clk) disable iff (!rst_n)
      rdErr && !anyErr |=> errSig_r == 3'h0)
      else $error("error signature not cleared on read");
   a_err_parity: assert property (@(posedge clk) disable iff (!rst_n)
      parityBad && !contention && !startBad && !timeoutEvt && !stopBad
      && phyCtrl_r[5] && !rdErr |=> errSig_r == $past(errSig_r))
      else $error("parity flagged while check off");
   a_err_contend: assert property (@(posedge clk) disable iff (!rst_n)
      contention |=> errSig_r == 3'h7)
      else $error("contention code wrong");
   a_no_reserved: assert property (@(posedge clk) disable iff (!rst_n)
      errSig_r != 3'h5 && errSig_r != 3'h6)
      else $error("reserved error code reported");
   a_asleep_flag: assert property (@(posedge clk) disable iff (!rst_n)
      regRead && regAddr == 4'hB |=> regRdata[4] == $past(sleepSync_r))
      else $error("asleep flag mismatch");
   a_rev_field: assert property (@(posedge clk) disable iff (!rst_n)
      regRead && regAddr == 4'h0 |=> regRdata[7:4] == 4'h3 && regRdata[3:0] == 4'h0)
      else $error("revision field wrong");
   a_guard_wait: assert property (@(posedge clk) disable iff (!rst_n)
      gap.start && txFirstByte && phyCtrl_r[2:0] == 3'h5 |=> gap.busy [*4] ##1 !gap.busy)
      else $error("guard time length wrong");
   a_sig_off: assert property (@(posedge clk) disable iff (!rst_n)
      txIsSignature && phyCtrl_r[3] |=> txSuppress)
      else $error("signature not suppressed");
   a_bus_block: assert property (@(posedge clk) disable iff (!rst_n)
      !hold_r && offSync_r |=> !busReachable)
      else $error("bus reachable with clock off");
   a_bus_held: assert property (@(posedge clk) disable iff (!rst_n)
      hold_r |=> busReachable)
      else $error("bus not reachable with clock held");

   // Error signature and access time-out checks; each code only when no higher code competes
   a_tmo_off: assert property (@(posedge clk) disable iff (!rst_n)
      phyCtrl_r[4] |-> !timeoutEvt)
      else $error("time-out raised while check off");
   a_tmo_code: assert property (@(posedge clk) disable iff (!rst_n)
      timeoutEvt && !contention && !startBad |=> errSig_r == 3'h3)
      else $error("time-out code wrong");
   a_tmo_clear: assert property (@(posedge clk) disable iff (!rst_n)
      timeoutEvt |=> !pending_r)
      else $error("access still pending after time-out");
   a_ack_clear: assert property (@(posedge clk) disable iff (!rst_n)
      accessAck |=> !pending_r)
      else $error("access still pending after acknowledge");
   a_start_code: assert property (@(posedge clk) disable iff (!rst_n)
      startBad && !contention |=> errSig_r == 3'h4)
      else $error("start bit code wrong");
   a_stop_code: assert property (@(posedge clk) disable iff (!rst_n)
      stopBad && !contention && !startBad && !timeoutEvt |=> errSig_r == 3'h2)
      else $error("stop bit code wrong");
   a_par_code: assert property (@(posedge clk) disable iff (!rst_n)
      parityBad && !phyCtrl_r[5] && !contention && !startBad && !timeoutEvt
      && !stopBad |=> errSig_r == 3'h1)
      else $error("parity code wrong");
   a_err_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !anyErr && !rdErr |=> errSig_r == $past(errSig_r))
      else $error("error signature changed without cause");

   // Transmit timing checks
   a_txgo_pulse: assert property (@(posedge clk) disable iff (!rst_n)
      txGo |=> !txGo)
      else $error("send pulse longer than one cycle");
   a_gap_len: assert property (@(posedge clk) disable iff (!rst_n)
      gap.start && !txFirstByte && phyCtrl_r[7] |=> ##23 gap.busy ##1 !gap.busy)
      else $error("inter-byte gap length wrong");
   a_no_gap: assert property (@(posedge clk) disable iff (!rst_n)
      gap.start && !txFirstByte && !phyCtrl_r[7] |=> !gap.busy)
      else $error("gap inserted while disabled");
   a_guard_off: assert property (@(posedge clk) disable iff (!rst_n)
      gap.start && txFirstByte && phyCtrl_r[2:0] == 3'h7 |=> !gap.busy)
      else $error("guard time inserted while off");
   a_guard_max: assert property (@(posedge clk) disable iff (!rst_n)
      gap.start && txFirstByte && phyCtrl_r[2:0] == 3'h0 |=> ##127 gap.busy ##1 !gap.busy)
      else $error("default guard time wrong");
   a_first_guard: assert property (@(posedge clk) disable iff (!rst_n)
      gap.start && txFirstByte && phyCtrl_r[2:0] == 3'h6 |=> gap.busy [*2] ##1 !gap.busy)
      else $error("first byte wait wrong");
   a_sig_kept: assert property (@(posedge clk) disable iff (!rst_n)
      !(txIsSignature && phyCtrl_r[3]) |=> !txSuppress)
      else $error("signature dropped while enabled");

   // Register map checks
   a_ctrl_rsvd: assert property (@(posedge clk) disable iff (!rst_n)
      !phyCtrl_r[6])
      else $error("reserved control bit set");
   a_dis_rsvd: assert property (@(posedge clk) disable iff (!rst_n)
      (phyDis_r & 8'hE3) == 8'h00)
      else $error("reserved disable bit set");
   a_sel_rsvd: assert property (@(posedge clk) disable iff (!rst_n)
      clkSel_r[7:2] == 6'h00)
      else $error("reserved clock select bit set");
   a_err_rsvd: assert property (@(posedge clk) disable iff (!rst_n)
      regRead && regAddr == 4'h1 |=> regRdata[7:3] == 5'h00)
      else $error("reserved error status bit set");
   a_stat_rsvd: assert property (@(posedge clk) disable iff (!rst_n)
      regRead && regAddr == 4'hB |=> regRdata[7:5] == 3'h0 && regRdata[3:0] == 4'h0)
      else $error("reserved system status bit set");
   a_unmapped_rd: assert property (@(posedge clk) disable iff (!rst_n)
      regRead && regAddr >= 4'h4 && regAddr <= 4'h6 |=> regRdata == 8'h00)
      else $error("unmapped offset not zero");
   a_rd_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !regRead |=> $stable(regRdata))
      else $error("read data changed without a read");
endmodule

// *** test/link_debugger_model.sv ***
`timescale 1ns/10ps
// Debugger side of the register port; every access goes through the link decoder
module link_debugger_model (
   input  wire logic       clk,
   input  wire logic [7:0] regRdata,
   output logic            regWrite,
   output logic            regRead,
   output logic [3:0]      regAddr,
   output logic [7:0]      regWdata
);
   initial begin
      regWrite = 1'b0;
      regRead  = 1'b0;
      regAddr  = 4'h0;
      regWdata = 8'h00;
   end

   // Register writes only through link instructions
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge clk);
      regAddr  = a;
      regWdata = d;
      regWrite = 1'b1;
      @(negedge clk);
      regWrite = 1'b0;
      // Released data is inverted so a stale value cannot pass
      regWdata = ~d;
   endtask

   // Register reads only through link instructions; data taken one cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(negedge clk);
      regAddr = a;
      regRead = 1'b1;
      @(negedge clk);
      regRead = 1'b0;
      @(negedge clk);
      d = regRdata;
   endtask
endmodule

// *** test/tb_debug_link_phy_config_status.sv ***
`timescale 1ns/10ps
module tb_debug_link_phy_config_status;
   logic       clk          = 1'b0;
   logic       rst_n        = 1'b0;
   logic       regWrite;
   logic       regRead;
   logic [3:0] regAddr;
   logic [7:0] regWdata;
   logic [7:0] regRdata;
   logic [3:0] errVec       = 4'h0;
   logic       accessReq    = 1'b0;
   logic       accessAck    = 1'b0;
   logic       sysSleepIdle = 1'b0;
   logic       cpuClockOff  = 1'b0;
   logic       txByteReq    = 1'b0;
   logic       txFirstByte  = 1'b0;
   logic       txIsSignature = 1'b0;
   logic       txGo;
   logic       txSuppress;
   logic       sysClockHold;
   logic       busReachable;
   logic [7:0] d;
   int         num_errors   = 0;
   int         n_checks     = 0;
   int         cycles       = 0;

   // Clock keeps running through every sleep setting
   always #5 clk = ~clk;

   link_debugger_model debugger (.clk(clk), .regRdata(regRdata), .regWrite(regWrite),
      .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata));

   debug_link_phy_config_status DUT (.clk(clk), .rst_n(rst_n), .regWrite(regWrite),
      .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
      .parityBad(errVec[0]), .stopBad(errVec[1]), .startBad(errVec[2]),
      .contention(errVec[3]), .accessReq(accessReq), .accessAck(accessAck),
      .sysSleepIdle(sysSleepIdle), .cpuClockOff(cpuClockOff), .txByteReq(txByteReq),
      .txFirstByte(txFirstByte), .txIsSignature(txIsSignature), .txGo(txGo),
      .txSuppress(txSuppress), .sysClockHold(sysClockHold), .busReachable(busReachable));

   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Ceiling covers the long access wait plus the transmit sweeps
   always @(posedge clk) begin
      cycles++;
      if (cycles == 90000) begin
         num_errors++;
         close_out();
      end
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic fire(input logic [3:0] v);
      @(negedge clk);
      errVec = v;
      @(negedge clk);
      errVec = 4'h0;
   endtask

   task automatic test_reset;
      debugger.rd(dbg_link_pkg::OFS_REV_STATUS, d);
      chk("revision", d, {dbg_link_pkg::INTERFACE_REVISION, 4'h0});
      debugger.rd(dbg_link_pkg::OFS_ERR_STATUS, d);
      chk("error reset", d, 8'h00);
      debugger.rd(dbg_link_pkg::OFS_PHY_CTRL, d);
      chk("control reset", d, 8'h00);
      debugger.rd(dbg_link_pkg::OFS_SYS_CTRL, d);
      chk("hold reset", d, 8'h01);
      chk("hold pin", sysClockHold, 1'b1);
      debugger.rd(dbg_link_pkg::OFS_CLK_SELECT, d);
      chk("clock select reset", d, 8'h03);
      $display("test reset done");
   endtask

   task automatic test_access;
      debugger.wr(dbg_link_pkg::OFS_PHY_CTRL, 8'hFF);
      debugger.rd(dbg_link_pkg::OFS_PHY_CTRL, d);
      chk("control mask", d, 8'hBF);
      debugger.wr(dbg_link_pkg::OFS_PHY_DIS_CTRL, 8'hFF);
      debugger.rd(dbg_link_pkg::OFS_PHY_DIS_CTRL, d);
      chk("disable mask", d, 8'h1C);
      debugger.wr(dbg_link_pkg::OFS_REV_STATUS, 8'hFF);
      debugger.rd(dbg_link_pkg::OFS_REV_STATUS, d);
      chk("revision ro", d, {dbg_link_pkg::INTERFACE_REVISION, 4'h0});
      for (int a = 4; a < 7; a++) begin
         debugger.rd(a[3:0], d);
         chk("unmapped", d, 8'h00);
      end
      debugger.wr(dbg_link_pkg::OFS_PHY_CTRL, 8'h00);
      debugger.wr(dbg_link_pkg::OFS_PHY_DIS_CTRL, 8'h00);
      $display("test access done");
   endtask

   task automatic test_errors;
      logic [7:0] codes [4];
      codes = '{8'h01, 8'h02, 8'h04, 8'h07};
      for (int k = 0; k < 4; k++) begin
         fire(4'h1 << k);
         debugger.rd(dbg_link_pkg::OFS_ERR_STATUS, d);
         chk("error code", d, codes[k]);
         debugger.rd(dbg_link_pkg::OFS_ERR_STATUS, d);
         chk("error cleared", d, 8'h00);
      end
      fire(4'h9);
      debugger.rd(dbg_link_pkg::OFS_ERR_STATUS, d);
      chk("error priority", d, 8'h07);
      debugger.wr(dbg_link_pkg::OFS_PHY_CTRL, 8'h20);
      fire(4'h1);
      debugger.rd(dbg_link_pkg::OFS_ERR_STATUS, d);
      chk("parity off", d, 8'h00);
      debugger.wr(dbg_link_pkg::OFS_PHY_CTRL, 8'h00);
      $display("test errors done");
   endtask

   task automatic test_timeout;
      @(negedge clk);
      accessReq = 1'b1;
      @(negedge clk);
      accessReq = 1'b0;
      repeat (65525) @(negedge clk);
      debugger.rd(dbg_link_pkg::OFS_ERR_STATUS, d);
      chk("no early timeout", d, 8'h00);
      repeat (20) @(negedge clk);
      debugger.rd(dbg_link_pkg::OFS_ERR_STATUS, d);
      chk("timeout code", d, 8'h03);
      $display("test timeout done");
   endtask

   task automatic test_sleep;
      cpuClockOff = 1'b1;
      repeat (6) @(negedge clk);
      chk("bus held", busReachable, 1'b1);
      debugger.wr(dbg_link_pkg::OFS_SYS_CTRL, 8'h00);
      repeat (6) @(negedge clk);
      chk("bus blocked", busReachable, 1'b0);
      chk("hold released", sysClockHold, 1'b0);
      sysSleepIdle = 1'b1;
      repeat (4) @(negedge clk);
      debugger.rd(dbg_link_pkg::OFS_SYS_STATUS, d);
      chk("asleep flag", d[dbg_link_pkg::ASLEEP_BIT], 1'b1);
      sysSleepIdle = 1'b0;
      cpuClockOff = 1'b0;
      repeat (6) @(negedge clk);
      debugger.rd(dbg_link_pkg::OFS_SYS_STATUS, d);
      chk("awake flag", d[dbg_link_pkg::ASLEEP_BIT], 1'b0);
      chk("bus back", busReachable, 1'b1);
      debugger.wr(dbg_link_pkg::OFS_SYS_CTRL, 8'h01);
      $display("test sleep done");
   endtask

   // Returns cycles from raising txByteReq to seeing txGo, and txSuppress seen with it
   task automatic send(input logic first, input logic sig, output int n, output logic sup);
      @(negedge clk);
      txFirstByte = first;
      txIsSignature = sig;
      txByteReq = 1'b1;
      @(negedge clk);
      txByteReq = 1'b0;
      n = 1;
      while (txGo !== 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      sup = txSuppress;
   endtask

   task automatic test_tx;
      int n;
      int e;
      logic sup;
      for (int s = 0; s < 8; s++) begin
         debugger.wr(dbg_link_pkg::OFS_PHY_CTRL, {5'h00, s[2:0]});
         send(1'b1, 1'b0, n, sup);
         e = (s == 7) ? 0 : (128 >> s);
         chk("guard delay", n >= e + 2 && n <= e + 3, 1'b1);
      end
      debugger.wr(dbg_link_pkg::OFS_PHY_CTRL, 8'h87);
      send(1'b1, 1'b0, n, sup);
      chk("first byte no gap", n >= 2 && n <= 3, 1'b1);
      send(1'b0, 1'b0, n, sup);
      chk("gap delay", n >= 26 && n <= 27, 1'b1);
      debugger.wr(dbg_link_pkg::OFS_PHY_CTRL, 8'h0F);
      send(1'b0, 1'b1, n, sup);
      chk("no gap", n >= 2 && n <= 3, 1'b1);
      chk("signature dropped", sup, 1'b1);
      debugger.wr(dbg_link_pkg::OFS_PHY_CTRL, 8'h07);
      send(1'b0, 1'b1, n, sup);
      chk("signature kept", sup, 1'b0);
      $display("test tx done");
   endtask

   initial begin
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      test_reset();
      test_access();
      test_errors();
      test_sleep();
      test_tx();
      test_timeout();
      close_out();
   end
endmodule
